/* File: inc/qos_sel_if.sv */
// Purpose: carries a qos table and a class select between modules
// Assumes: one clock
// Notes:   selector drives qos, bank drives table
`timescale 1ns/10ps
interface qos_sel_if;
  import tuning_pkg::*;
  logic [27:0] table_bits;
  xfer_kind_e  kind;
  prio_t       prio;
  qos_t        qos;
  modport bank (output table_bits, output kind, output prio, input qos);
  modport sel  (input table_bits, input kind, input prio, output qos);
endinterface

/* File: inc/tuning_cfg.svh */
// Purpose: offsets, field positions and reset values of the tuning bank
// Assumes: byte addresses on a 32-bit register port
// Notes:   guarded; definitions only
`ifndef TUNING_CFG_SVH
`define TUNING_CFG_SVH
`define ADDR_W                 16
`define OFF_WALK_CACHE_CONTROL 16'h8e00
`define OFF_TRANSACTION_QOS    16'h8e04
`define OFF_UNIT_CONFIG_INFO   16'h8e08
`define OFF_SECURE_UARCH_CTRL  16'h8e20
`define OFF_PER_NODE_CONTROL   16'h9000
`define OFF_WC_CAPACITY_MAX    16'h8e40
`define RST_WALK_CACHE_CONTROL 32'h0000_0000
`define RST_TRANSACTION_QOS    32'h0000_0000
`define RST_SECURE_UARCH_CTRL  32'h0000_0000
`define RST_PER_NODE_CONTROL   32'h0000_0000
`define RST_WC_CAPACITY_MAX    32'h0000_0000
`define QOS_WRITABLE_MASK      32'h0fff_ffff
`define NODE_CTRL_MASK         32'h0000_0013
`define BIT_EXCLUDE_SPACE_ID   19
`define BIT_CACHE_OFF_LO       8
`define BIT_NS_TUNING_PERMIT   0
`define POS_SYNC_QOS           24
`define POS_IRQ_QOS            20
`define POS_QUEUE_QOS          16
`define POS_SLOT_COUNT         4
`define DEF_SLOT_COUNT         12'd128
`define DEF_NUM_NODES          4
`endif

/* File: inc/tuning_pkg.sv */
// Purpose: shared types of the tuning bank
// Assumes: nothing
// Notes:   constants live in tuning_cfg.svh
package tuning_pkg;
  typedef logic [3:0] qos_t;
  typedef logic [1:0] prio_t;
  typedef enum logic [1:0] {XFER_SYNC, XFER_IRQ, XFER_QUEUE, XFER_WALK} xfer_kind_e;
endpackage

/* File: verification/tuning_regs_chk.sv */
// Purpose: port assertions for the tuning bank
// Assumes: one clock, synchronous active-low reset
// Notes:   secure or locked writes only, so the permit bit never matters here
`timescale 1ns/10ps
module tuning_regs_chk #(
  parameter int          NUM_NODES  = 4,
  parameter logic [11:0] SLOT_COUNT = 12'h080
)(
  // watched ports
  input wire logic                 i_clk, i_rstn, i_wr, i_rd, i_secure,
  input wire logic                 i_ns_enable, i_ns_enable_ack, i_s_enable, i_s_enable_ack,
  input wire logic [15:0]          i_addr,
  input wire logic [31:0]          i_wdata, o_rdata,
  input wire logic                 o_exclude_space_id_hash,
  input wire logic [7:0]           o_cache_off,
  input wire logic [NUM_NODES-1:0] i_node_req, o_node_grant,
  input wire logic [1:0]           i_xfer_kind, i_xfer_prio,
  input wire logic [3:0]           o_xfer_qos
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  logic lock, ns_scr_rd, qos_rd, cfg_rd;
  // decoded strobes, kept as nets so $past sees a plain signal
  assign lock = i_ns_enable | i_ns_enable_ack | i_s_enable | i_s_enable_ack;
  assign ns_scr_rd = i_rd && !i_secure && i_addr == 16'h8e20;
  assign qos_rd = i_rd && i_addr == 16'h8e04;
  assign cfg_rd = i_rd && i_secure && i_addr == 16'h8e08;
  function automatic logic [3:0] pick(logic [31:0] v, logic [1:0] k, logic [1:0] p);
    case (k)
      2'h0: return v[27:24];
      2'h1: return v[23:20];
      2'h2: return v[19:16];
      default: return v[4*p+:4];
    endcase
  endfunction
  sequence ctrl_wr;
    i_wr && i_secure && !lock && i_addr == 16'h8e00;
  endsequence
  sequence qos_wr;
    i_wr && i_secure && !lock && i_addr == 16'h8e04;
  endsequence
  ctrl_out_a: assert property (ctrl_wr |=> o_exclude_space_id_hash == $past(i_wdata[19])
    && o_cache_off == $past(i_wdata[15:8])) else $error("ctrl outputs wrong");
  lock_hold_a: assert property (i_wr && lock && i_addr == 16'h8e00 |=>
    $stable(o_cache_off) && $stable(o_exclude_space_id_hash)) else $error("locked write landed");
  qos_pick_a: assert property (qos_wr ##1 1'b1 |=> o_xfer_qos ==
    pick($past(i_wdata, 2), $past(i_xfer_kind), $past(i_xfer_prio))) else $error("qos pick wrong");
  secure_hide_a: assert property ($past(ns_scr_rd) |-> o_rdata == 32'h0)
    else $error("secure reg visible");
  qos_top_a: assert property ($past(qos_rd) |-> o_rdata[31:28] == 4'h0)
    else $error("qos top bits set");
  cfg_value_a: assert property ($past(cfg_rd) |-> o_rdata == {16'h0, SLOT_COUNT, 4'h0})
    else $error("slot count wrong");
  grant_ok_a: assert property ($onehot0(o_node_grant) && (o_node_grant & ~$past(i_node_req)) == '0)
    else $error("bad grant");
  grant_busy_a: assert property ($past(i_rstn) && $past(i_node_req) != '0 |-> o_node_grant != '0)
    else $error("request not granted");
endmodule // tuning_regs_chk

bind tuning_regs tuning_regs_chk #(.NUM_NODES(NUM_NODES), .SLOT_COUNT(SLOT_COUNT)) u_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_wr(i_wr), .i_rd(i_rd), .i_secure(i_secure),
  .i_ns_enable(i_ns_enable), .i_ns_enable_ack(i_ns_enable_ack), .i_s_enable(i_s_enable),
  .i_s_enable_ack(i_s_enable_ack), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .o_exclude_space_id_hash(o_exclude_space_id_hash), .o_cache_off(o_cache_off),
  .i_node_req(i_node_req), .o_node_grant(o_node_grant), .i_xfer_kind(i_xfer_kind),
  .i_xfer_prio(i_xfer_prio), .o_xfer_qos(o_xfer_qos));

/* File: verification/tuning_regs_test.sv */
// Purpose: self-checking bench for the tuning bank
// Assumes: checker bound to the design
// Notes:   register model held in bench variables
`timescale 1ns/10ps
module tuning_regs_test;
  logic        i_clk, i_rstn, i_wr, i_rd, i_secure, lck, permit_m;
  logic [3:0]  i_node_req, o_node_grant, o_xfer_qos;
  logic [1:0]  i_xfer_kind, i_xfer_prio;
  logic [15:0] i_addr, addrs [9];
  logic [31:0] i_wdata, o_rdata, ctrl_m, qos_m, node_m [4];
  logic [7:0]  o_cache_off;
  logic        o_exclude_space_id_hash, i_ns_enable, i_ns_enable_ack, i_s_enable, i_s_enable_ack;
  int          err_total, tests_run;
  tuning_regs #(.NUM_NODES(4), .SLOT_COUNT(12'h05a)) DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .i_secure(i_secure), .o_rdata(o_rdata), .i_ns_enable(i_ns_enable),
    .i_ns_enable_ack(i_ns_enable_ack), .i_s_enable(i_s_enable), .i_s_enable_ack(i_s_enable_ack),
    .o_exclude_space_id_hash(o_exclude_space_id_hash), .o_cache_off(o_cache_off),
    .i_node_req(i_node_req), .o_node_grant(o_node_grant), .i_xfer_kind(i_xfer_kind),
    .i_xfer_prio(i_xfer_prio), .o_xfer_qos(o_xfer_qos));
  // expected read data; non-secure sees nothing unless permitted, and never the secure register
  function automatic logic [31:0] exp_rd(logic [15:0] a, logic s);
    if (!s && (!permit_m || a == 16'h8e20)) return 32'h0;
    if (a == 16'h8e00) return ctrl_m;
    if (a == 16'h8e04) return qos_m;
    if (a == 16'h8e08) return 32'h0000_05a0;
    if (a[15:4] == 12'h900) return node_m[a[3:2]];
    return 32'h0;
  endfunction
  function automatic logic [3:0] exp_qos(logic [1:0] k, logic [1:0] p);
    return (k == 2'h3) ? qos_m[4*p+:4] : qos_m[24-4*k+:4];
  endfunction
  // highest priority wins, ties to the lowest node
  function automatic logic [3:0] exp_gnt(logic [3:0] r);
    int b;
    b = -1;
    for (int n = 0; n < 4; n++) if (r[n] && (b < 0 || node_m[n][1:0] > node_m[b][1:0])) b = n;
    return (b < 0) ? 4'h0 : 4'h1 << b;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (e !== g) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle write; model follows only what the bank should accept
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic s);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata, i_secure} <= {1'b1, a, d, s};
    @(posedge i_clk);
    i_wr <= 1'b0;
    if (s && a == 16'h8e20) permit_m = d[0];
    else if ((s || permit_m) && !lck && a == 16'h8e00) ctrl_m = d;
    else if ((s || permit_m) && !lck && a == 16'h8e04) qos_m = d & 32'h0fff_ffff;
    else if ((s || permit_m) && !lck && a[15:4] == 12'h900) node_m[a[3:2]] = d & 32'h13;
  endtask
  // secure read of the secure register has no modelled layout, so it is skipped
  task automatic rd(input logic [15:0] a, input logic s);
    @(posedge i_clk);
    {i_rd, i_addr, i_secure} <= {1'b1, a, s};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    if (!(s && a == 16'h8e20)) chk("rdata", exp_rd(a, s), o_rdata);
  endtask
  // enables only raised as a test of refusal, never to run translation
  task automatic set_lock(input logic [3:0] v);
    {i_ns_enable, i_ns_enable_ack, i_s_enable, i_s_enable_ack} <= v;
    lck = |v;
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial begin
    repeat (6000) @(posedge i_clk);
    err_total++;
    results();
  end
  initial begin
    {i_rstn, i_wr, i_rd, i_secure, i_addr, i_wdata, i_node_req, i_xfer_kind, i_xfer_prio} = '0;
    {ctrl_m, qos_m, permit_m, err_total, tests_run} = '0;
    node_m = '{default: 32'h0};
    set_lock(4'h0);
    addrs = '{16'h8e00, 16'h8e04, 16'h8e08, 16'h8e20, 16'h8ef0, 16'h9000, 16'h9004, 16'h9008,
              16'h900c};
    void'($urandom(32'h87ed));
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'b1;
    foreach (addrs[i]) rd(addrs[i], 1'b1);
    // spare bits kept, top qos nibble dropped, locked write refused
    wr(16'h8e00, 32'hffff_ffff, 1'b1);
    wr(16'h8e04, 32'hffff_ffff, 1'b1);
    set_lock(4'h1);
    wr(16'h8e00, 32'h0, 1'b1);
    rd(16'h8e00, 1'b0);
    rd(16'h8e00, 1'b1);
    rd(16'h8e04, 1'b1);
    repeat (80) begin
      set_lock(($urandom % 3 == 0) ? 4'($urandom) : 4'h0);
      wr(addrs[$urandom % 9], $urandom, 1'($urandom));
      rd(addrs[$urandom % 9], 1'($urandom));
      chk("hash", 32'(ctrl_m[19]), 32'(o_exclude_space_id_hash));
      chk("cache_off", 32'(ctrl_m[15:8]), 32'(o_cache_off));
    end
    set_lock(4'h0);
    wr(16'h8e04, $urandom, 1'b1);
    for (int k = 0; k < 16; k++) begin
      @(posedge i_clk);
      {i_xfer_kind, i_xfer_prio} <= 4'(k);
      @(posedge i_clk);
      #1;
      chk("qos", 32'(exp_qos(2'(k >> 2), 2'(k))), 32'(o_xfer_qos));
    end
    for (int n = 0; n < 4; n++) wr(16'h9000 + 16'(4 * n), $urandom, 1'b1);
    repeat (30) begin
      @(posedge i_clk);
      i_node_req <= 4'($urandom);
      @(posedge i_clk);
      #1;
      chk("grant", 32'(exp_gnt(i_node_req)), 32'(o_node_grant));
    end
    results();
  end
endmodule // tuning_regs_test

/* File: verilog/qos_selector.sv */
// Purpose: picks the qos value for one outgoing transaction
// Assumes: table registered in the bank
// Notes:   result registered, one cycle after the select
`timescale 1ns/10ps
`include "tuning_cfg.svh"
module qos_selector
  import tuning_pkg::*;
(
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rstn,
  // select port
  qos_sel_if.sel    q
);
  qos_t qos_reg;
  qos_t qos_next;

  // only the transaction's own class decides, plus its prio for walks, no boost from waiters
  always_comb begin
    unique case (q.kind)
      XFER_SYNC:  qos_next = q.table_bits[`POS_SYNC_QOS +: 4];
      XFER_IRQ:   qos_next = q.table_bits[`POS_IRQ_QOS +: 4];
      XFER_QUEUE: qos_next = q.table_bits[`POS_QUEUE_QOS +: 4];
      XFER_WALK:  qos_next = q.table_bits[{q.prio, 2'b00} +: 4];
    endcase
  end

  // output register
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      qos_reg <= 4'h0;
    end else begin
      qos_reg <= qos_next;
    end
  end
  assign q.qos = qos_reg;
endmodule // qos_selector

/* File: verilog/tuning_regs.sv */
// Purpose: tuning and status register bank of the translation control unit
// Assumes: one clock, plain register port, enables and acks from main control
// Notes:   read data valid the cycle after the read strobe
// Operation
// - secure control register hidden from non-secure
// - permit bit zero hides bank from non-secure
// - locked registers writable only when translation off
// - spare auxiliary bits store and read back
// - bit nineteen drops space id hash
// - bits fifteen to eight switch caches off
// - sync completion carries its qos field
// - interrupt writes carry their qos field
// - queue accesses carry their qos field
// - walk qos chosen by node priority
// - no qos boost for blocked transactions
// - config reports shared translation slot count
// - higher priority nodes served first
`timescale 1ns/10ps
`include "tuning_cfg.svh"
module tuning_regs
  import tuning_pkg::*;
#(
  parameter int          NUM_NODES  = `DEF_NUM_NODES,
  parameter logic [11:0] SLOT_COUNT = `DEF_SLOT_COUNT
)(
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_rstn,
  // register port
  input  wire logic [`ADDR_W-1:0]     i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  input  wire logic                   i_secure,
  output logic      [31:0]            o_rdata,
  // translation enable state from main control
  input  wire logic                   i_ns_enable,
  input  wire logic                   i_ns_enable_ack,
  input  wire logic                   i_s_enable,
  input  wire logic                   i_s_enable_ack,
  // walk cache controls
  output logic                        o_exclude_space_id_hash,
  output logic      [7:0]             o_cache_off,
  // node arbitration
  input  wire logic [NUM_NODES-1:0]   i_node_req,
  output logic      [NUM_NODES-1:0]   o_node_grant,
  // qos lookup
  input  wire logic [1:0]             i_xfer_kind,
  input  wire logic [1:0]             i_xfer_prio,
  output logic      [3:0]             o_xfer_qos
);
  localparam int NW = (NUM_NODES > 1) ? $clog2(NUM_NODES) : 1;

  logic [31:0] walk_cache_control_reg;
  logic [31:0] transaction_qos_levels_reg;
  logic [31:0] secure_uarch_control_reg;
  logic [31:0] walk_cache_capacity_max_reg;
  logic [31:0] per_node_control_reg [NUM_NODES];
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [NUM_NODES-1:0] grant_reg;
  logic [NUM_NODES-1:0] grant_next;
  logic        unlocked;
  logic        bank_ok;
  logic        sec_ok;
  logic        wr_ok;
  logic        node_hit;
  logic [NW-1:0] node_idx;
  logic [31:0] cfg_word;

  // access gates
  assign unlocked = !(i_ns_enable | i_ns_enable_ack | i_s_enable | i_s_enable_ack);
  assign sec_ok   = i_secure;
  assign bank_ok  = i_secure | secure_uarch_control_reg[`BIT_NS_TUNING_PERMIT];
  // locked writes outside the window are simply dropped, no error path
  assign wr_ok    = i_wr & bank_ok & unlocked;

  // node window decode, 4 bytes per node
  assign node_hit = (i_addr >= `OFF_PER_NODE_CONTROL) &&
                    (i_addr < `ADDR_W'(`OFF_PER_NODE_CONTROL + 4 * NUM_NODES)) &&
                    (i_addr[1:0] == 2'b00);
  assign node_idx = NW'((i_addr - `OFF_PER_NODE_CONTROL) >> 2);

  // configuration word is fixed at build time
  assign cfg_word = {16'h0000, SLOT_COUNT, 4'h0};

  // secure control register, never writable from non-secure
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      secure_uarch_control_reg <= `RST_SECURE_UARCH_CTRL;
    end else if (i_wr && sec_ok && i_addr == `OFF_SECURE_UARCH_CTRL) begin
      secure_uarch_control_reg <= {31'h0, i_wdata[`BIT_NS_TUNING_PERMIT]};
    end
  end

  // walk cache control, all bits stored including spare ones
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      walk_cache_control_reg <= `RST_WALK_CACHE_CONTROL;
    end else if (wr_ok && i_addr == `OFF_WALK_CACHE_CONTROL) begin
      walk_cache_control_reg <= i_wdata;
    end
  end

  // qos levels, top nibble reserved
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      transaction_qos_levels_reg <= `RST_TRANSACTION_QOS;
    end else if (wr_ok && i_addr == `OFF_TRANSACTION_QOS) begin
      transaction_qos_levels_reg <= i_wdata & `QOS_WRITABLE_MASK;
    end
  end

  // walk cache capacity limit, stored only
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      walk_cache_capacity_max_reg <= `RST_WC_CAPACITY_MAX;
    end else if (wr_ok && i_addr == `OFF_WC_CAPACITY_MAX) begin
      walk_cache_capacity_max_reg <= i_wdata;
    end
  end

  // per node control, priority and invalidation opt-out
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      for (int n = 0; n < NUM_NODES; n++) begin
        per_node_control_reg[n] <= `RST_PER_NODE_CONTROL;
      end
    end else if (wr_ok && node_hit) begin
      per_node_control_reg[node_idx] <= i_wdata & `NODE_CTRL_MASK;
    end
  end

  // read mux, blocked reads answer zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (i_rd) begin
      if (i_addr == `OFF_SECURE_UARCH_CTRL) begin
        if (sec_ok) begin
          rdata_next = secure_uarch_control_reg;
        end
      end else if (bank_ok) begin
        if (node_hit) begin
          rdata_next = per_node_control_reg[node_idx];
        end else begin
          unique case (i_addr)
            `OFF_WALK_CACHE_CONTROL: rdata_next = walk_cache_control_reg;
            `OFF_TRANSACTION_QOS:    rdata_next = transaction_qos_levels_reg;
            `OFF_UNIT_CONFIG_INFO:   rdata_next = cfg_word;
            `OFF_WC_CAPACITY_MAX:    rdata_next = walk_cache_capacity_max_reg;
            default:                 rdata_next = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // read data register, zero outside the answer cycle
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign o_rdata = rdata_reg;

  // walk cache steering straight from the stored bits
  assign o_exclude_space_id_hash = walk_cache_control_reg[`BIT_EXCLUDE_SPACE_ID];
  assign o_cache_off = walk_cache_control_reg[`BIT_CACHE_OFF_LO +: 8];

  // strict priority arbiter; ties go to the lowest node number
  always_comb begin
    logic       found;
    found      = 1'b0;
    grant_next = '0;
    for (int p = 3; p >= 0; p--) begin
      for (int n = 0; n < NUM_NODES; n++) begin
        if (!found && i_node_req[n] && per_node_control_reg[n][1:0] == 2'(p)) begin
          found         = 1'b1;
          grant_next[n] = 1'b1;
        end
      end
    end
  end

  // grant registered, one cycle after request
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      grant_reg <= '0;
    end else begin
      grant_reg <= grant_next;
    end
  end
  assign o_node_grant = grant_reg;

  // qos lookup in its own module
  qos_sel_if qif ();
  assign qif.table_bits = transaction_qos_levels_reg[27:0];
  assign qif.kind       = xfer_kind_e'(i_xfer_kind);
  assign qif.prio       = i_xfer_prio;

  qos_selector u_qos (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .q      (qif.sel)
  );
  assign o_xfer_qos = qif.qos;
endmodule // tuning_regs
